/* File: inc/lco_params.svh */
`ifndef LCO_PARAMS_SVH
`define LCO_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LCO_OFS_CMD 8'h00
`define LCO_OFS_OPERAND 8'h04
`define LCO_OFS_ACC 8'h08
`define LCO_OFS_FLAGS 8'h0C
`define LCO_OFS_PORT_A 8'h10
`define LCO_OFS_MEM_DATA 8'h14
`define LCO_OFS_STATUS 8'h18
`define LCO_OFS_RESULT 8'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LCO_FLD_ZERO 0
`define LCO_FLD_CARRY 1
`define LCO_FLD_AUX 2
`define LCO_FLD_OVF 3
`define LCO_FLD_BAD_OP 8
`define LCO_FLD_ADDR_LO 8

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define LCO_RST_BYTE 8'h00
`define LCO_RST_ADDR 4'h0
`define LCO_RESP_OKAY 2'h0
`define LCO_RESP_SLVERR 2'h2

`endif

/* File: inc/lco_pkg.sv */
package lco_pkg;

    typedef enum logic [3:0] {
        LCO_OP_NOP = 4'h0,
        LCO_OP_AND_A_IMM = 4'h1,
        LCO_OP_AND_A_MEM = 4'h2,
        LCO_OP_AND_MEM_A = 4'h3,
        LCO_OP_OR_A_IMM = 4'h4,
        LCO_OP_OR_A_MEM = 4'h5,
        LCO_OP_OR_MEM_A = 4'h6,
        LCO_OP_XOR_A_IMM = 4'h7,
        LCO_OP_XOR_A_MEM = 4'h8,
        LCO_OP_XOR_MEM_A = 4'h9,
        LCO_OP_XOR_IO_A = 4'hA,
        LCO_OP_NOT_A = 4'hB,
        LCO_OP_NOT_MEM = 4'hC,
        LCO_OP_NEG_A = 4'hD,
        LCO_OP_NEG_MEM = 4'hE,
        LCO_OP_BAD = 4'hF
    } lco_op_type;

    typedef enum logic [1:0] {
        LCO_DEST_NONE = 2'h0,
        LCO_DEST_ACC = 2'h1,
        LCO_DEST_MEM = 2'h2,
        LCO_DEST_PORT = 2'h3
    } lco_dest_type;

endpackage

/* File: core/lco_logic_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module lco_logic_unit (
    input wire lco_pkg::lco_op_type op_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] imm_in,
    input wire logic [7:0] mem_in,
    input wire logic [7:0] port_in,
    output logic [7:0] result_out,
    output lco_pkg::lco_dest_type dest_out,
    output logic zero_upd_out
);
    import lco_pkg::*;

    always_comb begin
        result_out = 8'h00;
        dest_out = LCO_DEST_NONE;
        unique case (op_in)
            LCO_OP_NOP, LCO_OP_BAD: begin
                result_out = 8'h00;
            end
            LCO_OP_AND_A_IMM: begin result_out = acc_in & imm_in; dest_out = LCO_DEST_ACC; end
            LCO_OP_AND_A_MEM: begin result_out = acc_in & mem_in; dest_out = LCO_DEST_ACC; end
            LCO_OP_AND_MEM_A: begin result_out = acc_in & mem_in; dest_out = LCO_DEST_MEM; end
            LCO_OP_OR_A_IMM: begin result_out = acc_in | imm_in; dest_out = LCO_DEST_ACC; end
            LCO_OP_OR_A_MEM: begin result_out = acc_in | mem_in; dest_out = LCO_DEST_ACC; end
            LCO_OP_OR_MEM_A: begin result_out = acc_in | mem_in; dest_out = LCO_DEST_MEM; end
            LCO_OP_XOR_A_IMM: begin result_out = acc_in ^ imm_in; dest_out = LCO_DEST_ACC; end
            LCO_OP_XOR_A_MEM: begin result_out = acc_in ^ mem_in; dest_out = LCO_DEST_ACC; end
            LCO_OP_XOR_MEM_A: begin result_out = acc_in ^ mem_in; dest_out = LCO_DEST_MEM; end
            LCO_OP_XOR_IO_A: begin result_out = acc_in ^ port_in; dest_out = LCO_DEST_PORT; end
            LCO_OP_NOT_A: begin result_out = ~acc_in; dest_out = LCO_DEST_ACC; end
            LCO_OP_NOT_MEM: begin result_out = ~mem_in; dest_out = LCO_DEST_MEM; end
            LCO_OP_NEG_A: begin result_out = 8'(~acc_in + 8'h01); dest_out = LCO_DEST_ACC; end
            LCO_OP_NEG_MEM: begin result_out = 8'(~mem_in + 8'h01); dest_out = LCO_DEST_MEM; end
        endcase
    end

    // The port write, like NOP and the bad code, leaves every flag alone.
    assign zero_upd_out = (dest_out == LCO_DEST_ACC) || (dest_out == LCO_DEST_MEM);

endmodule

`default_nettype wire

/* File: core/lco_logic_ops.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lco_params.svh"

//
// Contract
// - AND to accumulator combines it with an immediate or memory byte and stores it there.
// - OR to accumulator combines it with an immediate or memory byte and stores it there.
// - XOR to accumulator combines it with an immediate or memory byte and stores it there.
// - Memory-destination AND, OR and XOR write back to the same byte, accumulator unchanged.
// - XOR into port A data combines it with the accumulator and touches no flag.
// - All other logic, complement and negate forms change only the zero flag.
// - Accumulator complement inverts every accumulator bit in place.
// - Memory complement inverts every bit of the addressed byte in place.
// - Accumulator negate replaces it by its two's complement modulo 256.
// - Memory negate replaces the addressed byte by its two's complement.
module lco_logic_ops (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [7:0] port_a_out_data_out,
    output logic [3:0] status_flags_out
);
    import lco_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] accumulator;
    logic [7:0] port_a_out_data;
    logic [7:0] imm_byte;
    logic [3:0] mem_addr;
    logic zero_flag;
    logic carry_flag;
    logic aux_carry_flag;
    logic overflow_flag;
    logic [3:0] last_op;
    logic [7:0] last_result;
    logic bad_op;
    logic [7:0] data_mem [0:15];

    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_go;
    logic [7:0] wr_ofs;
    logic wr_cmd;
    logic wr_operand;
    logic wr_acc;
    logic wr_flags;
    logic wr_port;
    logic wr_mem;
    logic wr_status;
    logic wr_hit;
    logic lane0;
    logic lane1;

    assign aw_fire = s_axi_awvalid_in && s_axi_awready_out;
    assign w_fire = s_axi_wvalid_in && s_axi_wready_out;
    assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
    assign wr_go = aw_held && w_held && !s_axi_bvalid_out;
    assign wr_ofs = {aw_addr_q[7:2], 2'b00};
    assign lane0 = w_strb_q[0];
    assign lane1 = w_strb_q[1];
    assign wr_cmd = wr_go && (wr_ofs == `LCO_OFS_CMD);
    assign wr_operand = wr_go && (wr_ofs == `LCO_OFS_OPERAND);
    assign wr_acc = wr_go && (wr_ofs == `LCO_OFS_ACC) && lane0;
    assign wr_flags = wr_go && (wr_ofs == `LCO_OFS_FLAGS) && lane0;
    assign wr_port = wr_go && (wr_ofs == `LCO_OFS_PORT_A) && lane0;
    assign wr_mem = wr_go && (wr_ofs == `LCO_OFS_MEM_DATA) && lane0;
    assign wr_status = wr_go && (wr_ofs == `LCO_OFS_STATUS) && lane1;
    // The result register is read-only, so a write to it is refused.
    assign wr_hit = (wr_ofs <= `LCO_OFS_STATUS);

    // ------------------------------------------------------------------
    // Operation launch
    // ------------------------------------------------------------------
    // An operation runs in the very cycle its command write is committed,
    // so no other bus write can race it for the same destination.
    logic exec;
    lco_op_type exec_op;
    logic [7:0] mem_byte;
    logic [7:0] unit_result;
    lco_dest_type unit_dest;
    logic unit_zero_upd;
    logic to_acc;
    logic to_mem;
    logic to_port;

    assign exec = wr_cmd && lane0;
    assign exec_op = lco_op_type'(w_data_q[3:0]);
    assign mem_byte = data_mem[mem_addr];
    assign to_acc = exec && (unit_dest == LCO_DEST_ACC);
    assign to_mem = exec && (unit_dest == LCO_DEST_MEM);
    assign to_port = exec && (unit_dest == LCO_DEST_PORT);

    lco_logic_unit u_unit (
        .op_in(exec_op),
        .acc_in(accumulator),
        .imm_in(imm_byte),
        .mem_in(mem_byte),
        .port_in(port_a_out_data),
        .result_out(unit_result),
        .dest_out(unit_dest),
        .zero_upd_out(unit_zero_upd)
    );

    // ------------------------------------------------------------------
    // Datapath registers
    // ------------------------------------------------------------------
    // accumulator destination.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            accumulator <= `LCO_RST_BYTE;
        end else if (to_acc) begin
            accumulator <= unit_result;
        end else if (wr_acc) begin
            accumulator <= w_data_q[7:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            port_a_out_data <= `LCO_RST_BYTE;
        end else if (to_port) begin
            port_a_out_data <= unit_result;
        end else if (wr_port) begin
            port_a_out_data <= w_data_q[7:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (to_mem) begin
            data_mem[mem_addr] <= unit_result;
        end else if (wr_mem) begin
            data_mem[mem_addr] <= w_data_q[7:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            imm_byte <= `LCO_RST_BYTE;
            mem_addr <= `LCO_RST_ADDR;
        end else if (wr_operand) begin
            if (lane0) begin
                imm_byte <= w_data_q[7:0];
            end
            if (lane1) begin
                mem_addr <= w_data_q[`LCO_FLD_ADDR_LO +: 4];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            zero_flag <= 1'b0;
        end else if (exec && unit_zero_upd) begin
            zero_flag <= (unit_result == 8'h00);
        end else if (wr_flags) begin
            zero_flag <= w_data_q[`LCO_FLD_ZERO];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            carry_flag <= 1'b0;
            aux_carry_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else if (wr_flags) begin
            carry_flag <= w_data_q[`LCO_FLD_CARRY];
            aux_carry_flag <= w_data_q[`LCO_FLD_AUX];
            overflow_flag <= w_data_q[`LCO_FLD_OVF];
        end
    end

    // A bad code runs as a no-op but stays visible until software clears it.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            last_op <= 4'h0;
            last_result <= `LCO_RST_BYTE;
            bad_op <= 1'b0;
        end else begin
            if (exec) begin
                last_op <= w_data_q[3:0];
                last_result <= unit_result;
            end
            if (exec && (exec_op == LCO_OP_BAD)) begin
                bad_op <= 1'b1;
            end else if (wr_status && w_data_q[`LCO_FLD_BAD_OP]) begin
                bad_op <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            port_a_out_data_out <= `LCO_RST_BYTE;
            status_flags_out <= 4'h0;
        end else begin
            port_a_out_data_out <= port_a_out_data;
            status_flags_out <= {overflow_flag, aux_carry_flag, carry_flag, zero_flag};
        end
    end

    // ------------------------------------------------------------------
    // Bus write channels
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            s_axi_awready_out <= s_axi_awvalid_in && !s_axi_awready_out && !aw_held;
            s_axi_wready_out <= s_axi_wvalid_in && !s_axi_wready_out && !w_held;
            if (aw_fire) begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr_in;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (w_fire) begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `LCO_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_hit ? `LCO_RESP_OKAY : `LCO_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Bus read channels
    // ------------------------------------------------------------------
    logic [7:0] rd_ofs;
    logic rd_hit;
    logic [31:0] rd_mux;

    assign rd_ofs = {s_axi_araddr_in[7:2], 2'b00};
    assign rd_hit = (rd_ofs <= `LCO_OFS_RESULT);
    assign rd_mux =
        (rd_ofs == `LCO_OFS_CMD) ? {28'h0, last_op} :
        (rd_ofs == `LCO_OFS_OPERAND) ? {20'h0, mem_addr, imm_byte} :
        (rd_ofs == `LCO_OFS_ACC) ? {24'h0, accumulator} :
        (rd_ofs == `LCO_OFS_FLAGS) ?
            {28'h0, overflow_flag, aux_carry_flag, carry_flag, zero_flag} :
        (rd_ofs == `LCO_OFS_PORT_A) ? {24'h0, port_a_out_data} :
        (rd_ofs == `LCO_OFS_MEM_DATA) ? {24'h0, mem_byte} :
        (rd_ofs == `LCO_OFS_STATUS) ? {23'h0, bad_op, 4'h0, last_op} :
        (rd_ofs == `LCO_OFS_RESULT) ? {24'h0, last_result} : 32'h0000_0000;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `LCO_RESP_OKAY;
        end else begin
            s_axi_arready_out <= s_axi_arvalid_in && !s_axi_arready_out && !s_axi_rvalid_out;
            if (ar_fire) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_mux;
                s_axi_rresp_out <= rd_hit ? `LCO_RESP_OKAY : `LCO_RESP_SLVERR;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking lco_cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    and_acc_a: assert property (
        (exec && exec_op == LCO_OP_AND_A_IMM)
        |=> accumulator == ($past(accumulator) & $past(imm_byte)))
        else $error("AND into accumulator gave a wrong value");

    or_acc_a: assert property (
        (exec && exec_op == LCO_OP_OR_A_MEM)
        |=> accumulator == ($past(accumulator) | $past(mem_byte)))
        else $error("OR into accumulator gave a wrong value");

    xor_acc_a: assert property (
        (exec && exec_op == LCO_OP_XOR_A_IMM)
        |=> accumulator == ($past(accumulator) ^ $past(imm_byte)))
        else $error("XOR into accumulator gave a wrong value");

    mem_dest_a: assert property (
        (exec && exec_op == LCO_OP_XOR_MEM_A)
        |=> accumulator == $past(accumulator)
            && data_mem[$past(mem_addr)] == ($past(accumulator) ^ $past(mem_byte)))
        else $error("Memory destination write back is wrong");

    xor_port_a: assert property (
        (exec && exec_op == LCO_OP_XOR_IO_A)
        |=> port_a_out_data == ($past(accumulator) ^ $past(port_a_out_data))
            && $stable(zero_flag) ##1 status_flags_out[`LCO_FLD_ZERO] == zero_flag)
        else $error("Port XOR wrong or a flag moved");

    flags_hold_a: assert property (
        (exec && !wr_flags) |=> $stable(carry_flag) && $stable(aux_carry_flag)
            && $stable(overflow_flag))
        else $error("An operation disturbed a flag other than zero");

    not_acc_a: assert property (
        (exec && exec_op == LCO_OP_NOT_A) |=> accumulator == ~$past(accumulator))
        else $error("Accumulator complement is wrong");

    not_mem_a: assert property (
        (exec && exec_op == LCO_OP_NOT_MEM)
        |=> data_mem[$past(mem_addr)] == ~$past(mem_byte))
        else $error("Memory complement is wrong");

    neg_acc_a: assert property (
        (exec && exec_op == LCO_OP_NEG_A)
        |=> 8'(accumulator + $past(accumulator)) == 8'h00)
        else $error("Accumulator negate is wrong");

    neg_mem_a: assert property (
        (exec && exec_op == LCO_OP_NEG_MEM)
        |=> 8'(data_mem[$past(mem_addr)] + $past(mem_byte)) == 8'h00)
        else $error("Memory negate is wrong");

    zero_track_a: assert property (
        (exec && unit_zero_upd)
        |=> zero_flag == (last_result == 8'h00) ##1 status_flags_out[0] == $past(zero_flag))
        else $error("Zero flag does not follow the result");

endmodule

`default_nettype wire

/* File: dv/lco_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Core-side register master
// ----------------------------------------------------------------------
// Released address and data lines show the inverse of the last value.
// A stale word therefore never reads as if it were still being offered.
module lco_core_model (
    input wire logic clk_in,
    output logic [7:0] awaddr_out,
    output logic awvalid_out,
    input wire logic awready_in,
    output logic [31:0] wdata_out,
    output logic [3:0] wstrb_out,
    output logic wvalid_out,
    input wire logic wready_in,
    input wire logic [1:0] bresp_in,
    input wire logic bvalid_in,
    output logic bready_out,
    output logic [7:0] araddr_out,
    output logic arvalid_out,
    input wire logic arready_in,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in,
    input wire logic rvalid_in,
    output logic rready_out
);
    initial begin
        awaddr_out = 8'h00;
        awvalid_out = 1'b0;
        wdata_out = 32'h0;
        wstrb_out = 4'h0;
        wvalid_out = 1'b0;
        bready_out = 1'b0;
        araddr_out = 8'h00;
        arvalid_out = 1'b0;
        rready_out = 1'b0;
    end

    task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        begin
            done = 1'b0;
            @(posedge clk_in);
            awaddr_out <= a;
            wdata_out <= d;
            wstrb_out <= 4'hF;
            awvalid_out <= 1'b1;
            wvalid_out <= 1'b1;
            bready_out <= 1'b1;
            while (!done) begin
                @(posedge clk_in);
                if (awvalid_out && awready_in) begin
                    awvalid_out <= 1'b0;
                    awaddr_out <= ~a;
                end
                if (wvalid_out && wready_in) begin
                    wvalid_out <= 1'b0;
                    wdata_out <= ~d;
                end
                if (bvalid_in) begin
                    r = bresp_in;
                    done = 1'b1;
                end
            end
            bready_out <= 1'b0;
        end
    endtask

    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        begin
            done = 1'b0;
            @(posedge clk_in);
            araddr_out <= a;
            arvalid_out <= 1'b1;
            rready_out <= 1'b1;
            while (!done) begin
                @(posedge clk_in);
                if (arvalid_out && arready_in) begin
                    arvalid_out <= 1'b0;
                    araddr_out <= ~a;
                end
                if (rvalid_in) begin
                    d = rdata_in;
                    r = rresp_in;
                    done = 1'b1;
                end
            end
            rready_out <= 1'b0;
        end
    endtask
endmodule

`default_nettype wire

/* File: dv/lco_logic_ops_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lco_params.svh"

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end

module lco_logic_ops_tb;
    import lco_pkg::*;

    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    int error_cnt = 0;
    int checked = 0;
    logic [1:0] resp;
    logic [7:0] awaddr, araddr, port_pins;
    logic [31:0] wdata, rdata, rd_word;
    logic [3:0] wstrb, flag_pins;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;

    always #4 core_clk_in = ~core_clk_in;

    lco_core_model u_lco_core_model (.clk_in(core_clk_in), .awaddr_out(awaddr),
        .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
        .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid),
        .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
        .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid),
        .rready_out(rready));

    lco_logic_ops u_lco_logic_ops (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .port_a_out_data_out(port_pins), .status_flags_out(flag_pins));

    // ----------------------------------------------------------------------
    // Bus helpers
    // ----------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_lco_core_model.write(a, d, resp);
    endtask

    task automatic rd(input logic [7:0] a);
        u_lco_core_model.read(a, rd_word, resp);
    endtask

    // Carry, aux and overflow are preset high so any stray update shows up.
    task automatic exec(input lco_op_type op, input logic [7:0] a0, m0, imm, ea, em,
                        input logic ez);
        wr(`LCO_OFS_ACC, {24'h0, a0});
        wr(`LCO_OFS_OPERAND, {20'h0, 4'h5, imm});
        wr(`LCO_OFS_MEM_DATA, {24'h0, m0});
        wr(`LCO_OFS_FLAGS, 32'h0000000E);
        wr(`LCO_OFS_CMD, {28'h0, op});
        rd(`LCO_OFS_ACC);
        `CHK("acc", ea, rd_word[7:0])
        rd(`LCO_OFS_MEM_DATA);
        `CHK("mem", em, rd_word[7:0])
        rd(`LCO_OFS_FLAGS);
        `CHK("flags", {3'h7, ez}, rd_word[3:0])
        `CHK("flag_pins", {3'h7, ez}, flag_pins)
    endtask

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    task automatic t_reset;
        rd(`LCO_OFS_ACC);
        `CHK("acc_rst", 8'h00, rd_word[7:0])
        rd(`LCO_OFS_PORT_A);
        `CHK("port_rst", 8'h00, rd_word[7:0])
        `CHK("pins_rst", 12'h000, {port_pins, flag_pins})
    endtask

    task automatic t_and;
        exec(LCO_OP_AND_A_IMM, 8'hF0, 8'h33, 8'h3C, 8'h30, 8'h33, 1'b0);
        exec(LCO_OP_AND_A_MEM, 8'h0F, 8'hF0, 8'hFF, 8'h00, 8'hF0, 1'b1);
        exec(LCO_OP_AND_MEM_A, 8'h5A, 8'h0F, 8'hFF, 8'h5A, 8'h0A, 1'b0);
    endtask

    task automatic t_or;
        exec(LCO_OP_OR_A_IMM, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 1'b1);
        exec(LCO_OP_OR_A_MEM, 8'h12, 8'h40, 8'h00, 8'h52, 8'h40, 1'b0);
        exec(LCO_OP_OR_MEM_A, 8'h81, 8'h18, 8'h00, 8'h81, 8'h99, 1'b0);
    endtask

    task automatic t_xor;
        exec(LCO_OP_XOR_A_IMM, 8'hFF, 8'h01, 8'hFF, 8'h00, 8'h01, 1'b1);
        exec(LCO_OP_XOR_A_MEM, 8'h0F, 8'h3C, 8'h0F, 8'h33, 8'h3C, 1'b0);
        exec(LCO_OP_XOR_MEM_A, 8'hA5, 8'hA5, 8'h00, 8'hA5, 8'h00, 1'b1);
    endtask

    task automatic t_cpl;
        exec(LCO_OP_NOT_A, 8'h38, 8'h11, 8'h00, 8'hC7, 8'h11, 1'b0);
        exec(LCO_OP_NOT_A, 8'hFF, 8'h11, 8'h00, 8'h00, 8'h11, 1'b1);
        exec(LCO_OP_NOT_MEM, 8'h11, 8'h38, 8'h00, 8'h11, 8'hC7, 1'b0);
        exec(LCO_OP_NEG_A, 8'h38, 8'h22, 8'h00, 8'hC8, 8'h22, 1'b0);
        exec(LCO_OP_NEG_A, 8'h00, 8'h22, 8'h00, 8'h00, 8'h22, 1'b1);
        exec(LCO_OP_NEG_MEM, 8'h33, 8'h38, 8'h00, 8'h33, 8'hC8, 1'b0);
        exec(LCO_OP_NEG_MEM, 8'h33, 8'h80, 8'h00, 8'h33, 8'h80, 1'b0);
    endtask

    // Carry, aux and overflow start high and zero low, so a zero result must leave all four.
    task automatic t_port;
        wr(`LCO_OFS_PORT_A, 32'h0000003C);
        wr(`LCO_OFS_ACC, 32'h0000003C);
        wr(`LCO_OFS_FLAGS, 32'h0000000E);
        wr(`LCO_OFS_CMD, {28'h0, LCO_OP_XOR_IO_A});
        rd(`LCO_OFS_PORT_A);
        `CHK("port", 8'h00, rd_word[7:0])
        `CHK("port_pins", 8'h00, port_pins)
        `CHK("io_flags", 4'hE, flag_pins)
        wr(`LCO_OFS_ACC, 32'h0000000F);
        wr(`LCO_OFS_CMD, {28'h0, LCO_OP_XOR_IO_A});
        rd(`LCO_OFS_ACC);
        `CHK("io_acc", 8'h0F, rd_word[7:0])
        rd(`LCO_OFS_RESULT);
        `CHK("io_result", 8'h0F, rd_word[7:0])
        rd(`LCO_OFS_CMD);
        `CHK("last_cmd", 4'hA, rd_word[3:0])
        `CHK("port_pins2", 8'h0F, port_pins)
    endtask

    task automatic t_bus;
        exec(LCO_OP_NOP, 8'h00, 8'h44, 8'h00, 8'h00, 8'h44, 1'b0);
        exec(LCO_OP_BAD, 8'h00, 8'h44, 8'h00, 8'h00, 8'h44, 1'b0);
        rd(`LCO_OFS_STATUS);
        `CHK("bad_op", 9'h10F, rd_word[8:0])
        wr(`LCO_OFS_STATUS, 32'h00000100);
        rd(`LCO_OFS_STATUS);
        `CHK("bad_clr", 9'h00F, rd_word[8:0])
        rd(8'h20);
        `CHK("rd_unmapped", `LCO_RESP_SLVERR, resp)
        wr(`LCO_OFS_RESULT, 32'h00000055);
        `CHK("wr_result", `LCO_RESP_SLVERR, resp)
        wr(8'h24, 32'h00000055);
        `CHK("wr_unmapped", `LCO_RESP_SLVERR, resp)
        wr(`LCO_OFS_ACC, 32'h00000077);
        `CHK("wr_okay", `LCO_RESP_OKAY, resp)
    endtask

    // ----------------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------------
    task automatic results;
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_and();
        t_or();
        t_xor();
        t_cpl();
        t_port();
        t_bus();
        results();
    end

    // The whole sequence takes under a thousand cycles; this bound leaves wide margin.
    initial begin
        repeat (20000) @(posedge core_clk_in);
        error_cnt++;
        results();
    end
endmodule

`default_nettype wire
